// ==== design/autocal_pkg.sv ====
// Purpose: constants and types for the automatic calibration sequencer
// Assumes: 25 MHz aclk, AXI4-Lite register access
// Notes:   readings arrive on a half-second tick
package autocal_pkg;
    // Register byte offsets
    localparam logic [7:0] CFG_OFS      = 8'h00;
    localparam logic [7:0] INTERVAL_OFS = 8'h04;
    localparam logic [7:0] PURGE_OFS    = 8'h08;
    localparam logic [7:0] CMD_OFS      = 8'h0C;
    localparam logic [7:0] STATUS_OFS   = 8'h10;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0] IRQ_CLR_OFS  = 8'h18;
    localparam logic [7:0] IRQ_EN_OFS   = 8'h1C;
    localparam logic [7:0] ZERO_CAL_OFS = 8'h20;
    localparam logic [7:0] SPAN_CAL_OFS = 8'h24;
    // Field positions
    localparam int CMD_START_BIT = 0;
    localparam int CMD_ACK_BIT   = 1;
    localparam int EV_DONE       = 0;
    localparam int EV_CAL_FAIL   = 1;
    localparam int EV_DRIFT_FAIL = 2;
    localparam int AL_CAL        = 0;
    localparam int AL_LOW_FLOW   = 1;
    // Reset values
    localparam logic [15:0] INTERVAL_RST = 16'h0000;
    localparam logic [15:0] PURGE_RST    = 16'h001E;
    localparam logic [21:0] CAL_RST      = 22'h000000;
    // Timing
    localparam longint CLK_NS        = 40;
    localparam longint HALF_SEC_NS   = 500_000_000;
    localparam longint HALF_SEC_CYC  = HALF_SEC_NS / CLK_NS;
    localparam int     WINDOW_S      = 20;
    localparam int     TICKS_PER_S   = 2;
    localparam logic [5:0]  READINGS = 6'(WINDOW_S * TICKS_PER_S);
    localparam logic [12:0] TICKS_PER_HOUR = 13'(3600 * TICKS_PER_S);
    // Checks
    localparam logic [2:0]  ATTEMPT_MAX  = 3'h5;
    localparam logic [5:0]  DRIFT_MARGIN = 6'h0A;
    localparam logic [15:0] REF_DELTA    = 16'h4000;
    localparam int          TOL_PCT      = 30;

    typedef struct packed {
        logic freeze;
        logic full;
    } cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_PRE, ST_COLLECT, ST_POST, ST_CHECK
    } state_t;
endpackage : autocal_pkg

// ==== design/autocal_sequencer.sv ====
// Purpose: automatic zero/span calibration sequencer with AXI4-Lite registers
// Assumes: sample_data is the live reading, synchronous to aclk
// Notes:   calibration values are sums of one window of readings
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module autocal_sequencer import autocal_pkg::*; #(
    parameter longint TICK_CYCLES = HALF_SEC_CYC
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Measurement and front panel
    input  wire logic [15:0] sample_data,
    input  wire logic        up_button,
    output logic [15:0]      out_value,
    output logic             cal_alarm,
    output logic             low_flow_failure_alarm,
    // Valves and interrupt
    output logic             zero_valve,
    output logic             span_valve,
    output logic             irq
);
    function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

    function automatic logic delta_ok(input logic [21:0] z, input logic [21:0] s);
        logic [31:0] ref_sum;
        logic [31:0] d;
        ref_sum = 32'(REF_DELTA) * 32'(READINGS);
        d = (s > z) ? 32'(s - z) : 32'h0;
        delta_ok = (s > z) && (absdiff(d, ref_sum) * 32'h64 <= ref_sum * 32'(TOL_PCT));
    endfunction : delta_ok

    cfg_t        cfg;
    logic [15:0] interval;
    logic [15:0] purge;
    logic [2:0]  irq_en;
    logic [2:0]  irq_stat;
    state_t      state;
    logic        phase_span;
    logic [2:0]  attempts;
    logic [21:0] zero_cal;
    logic [21:0] span_cal;
    logic [21:0] prev_zero;
    logic [21:0] prev_span;
    logic [21:0] sum;
    logic [15:0] prev_rd;
    logic [5:0]  rd_cnt;
    logic [5:0]  inc_cnt;
    logic [5:0]  dec_cnt;
    logic [16:0] timer;
    logic [31:0] tick_cnt;
    logic        tick;
    logic [12:0] hour_ticks;
    logic [15:0] hours;
    logic        sched_pend;
    logic        sw_start;
    logic [1:0]  alarm;
    logic [1:0]  cond;
    logic [1:0]  ackd;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic        do_wr;
    logic        wr_ok;
    logic [2:0]  ev;
    logic        busy;
    logic        start;
    logic        drift;
    logic        last_rd;
    logic        ack;
    logic        gas_on;

    assign busy    = (state != ST_IDLE);
    assign start   = !busy && (sched_pend || sw_start);
    // Readings wait until the phase's gas valve is open
    assign gas_on  = phase_span ? span_valve : zero_valve;
    assign last_rd = (state == ST_COLLECT) && tick && gas_on && (rd_cnt == READINGS - 6'h01);
    assign drift   = inc_cnt > dec_cnt + DRIFT_MARGIN;
    assign do_wr   = aw_got && w_got && !s_axi_bvalid;
    assign ack     = up_button || (do_wr && waddr == CMD_OFS && wdata[CMD_ACK_BIT]);
    assign wr_ok   = waddr == CFG_OFS || waddr == INTERVAL_OFS || waddr == PURGE_OFS
                  || waddr == CMD_OFS || waddr == IRQ_CLR_OFS || waddr == IRQ_EN_OFS;

    // AXI write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            waddr         <= 8'h00;
            wdata         <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_got        <= 1'b1;
                waddr         <= s_axi_awaddr;
            end else if (!aw_got && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_got        <= 1'b1;
                wdata        <= s_axi_wdata;
            end else if (!w_got && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (do_wr) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg      <= '0;
            interval <= INTERVAL_RST;
            purge    <= PURGE_RST;
            irq_en   <= 3'h0;
            sw_start <= 1'b0;
        end else begin
            if (start) begin
                sw_start <= 1'b0;
            end
            if (do_wr) begin
                if (waddr == CFG_OFS) begin
                    cfg <= wdata[1:0];
                end else if (waddr == INTERVAL_OFS) begin
                    interval <= wdata[15:0];
                end else if (waddr == PURGE_OFS) begin
                    purge <= wdata[15:0];
                end else if (waddr == CMD_OFS && wdata[CMD_START_BIT]) begin
                    sw_start <= 1'b1;
                end else if (waddr == IRQ_EN_OFS) begin
                    irq_en <= wdata[2:0];
                end
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            if (s_axi_araddr == CFG_OFS) begin
                s_axi_rdata <= {30'h0, cfg};
            end else if (s_axi_araddr == INTERVAL_OFS) begin
                s_axi_rdata <= {16'h0, interval};
            end else if (s_axi_araddr == PURGE_OFS) begin
                s_axi_rdata <= {16'h0, purge};
            end else if (s_axi_araddr == STATUS_OFS) begin
                s_axi_rdata <= {22'h0, busy, alarm, attempts, phase_span, state};
            end else if (s_axi_araddr == IRQ_STAT_OFS) begin
                s_axi_rdata <= {29'h0, irq_stat};
            end else if (s_axi_araddr == IRQ_EN_OFS) begin
                s_axi_rdata <= {29'h0, irq_en};
            end else if (s_axi_araddr == ZERO_CAL_OFS) begin
                s_axi_rdata <= {10'h0, zero_cal};
            end else if (s_axi_araddr == SPAN_CAL_OFS) begin
                s_axi_rdata <= {10'h0, span_cal};
            end else if (s_axi_araddr == CMD_OFS || s_axi_araddr == IRQ_CLR_OFS) begin
                s_axi_rdata <= 32'h0;
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Half-second tick and hour scheduler
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt   <= 32'h0;
            tick       <= 1'b0;
            hour_ticks <= 13'h0;
            hours      <= 16'h0;
            sched_pend <= 1'b0;
        end else begin
            tick     <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
            if (interval == 16'h0) begin
                hour_ticks <= 13'h0;
                hours      <= 16'h0;
                sched_pend <= 1'b0;
            end else begin
                if (start) begin
                    sched_pend <= 1'b0;
                end
                if (tick) begin
                    hour_ticks <= (hour_ticks == TICKS_PER_HOUR - 13'h1) ? 13'h0
                                                                           : hour_ticks + 13'h1;
                end
                if (hours >= interval) begin
                    hours      <= 16'h0;
                    sched_pend <= 1'b1;
                end else if (tick && hour_ticks == TICKS_PER_HOUR - 13'h1) begin
                    hours <= hours + 16'h1;
                end
            end
        end
    end

    // Calibration sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= ST_IDLE;
            phase_span <= 1'b0;
            attempts   <= 3'h0;
            zero_cal   <= CAL_RST;
            span_cal   <= CAL_RST;
            prev_zero  <= CAL_RST;
            prev_span  <= CAL_RST;
            sum        <= 22'h0;
            prev_rd    <= 16'h0;
            rd_cnt     <= 6'h0;
            inc_cnt    <= 6'h0;
            dec_cnt    <= 6'h0;
            timer      <= 17'h0;
            ev         <= 3'h0;
            cond       <= 2'h0;
        end else begin
            ev <= 3'h0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        prev_zero  <= zero_cal;
                        prev_span  <= span_cal;
                        phase_span <= 1'b0;
                        attempts   <= 3'h0;
                        timer      <= {purge, 1'b0};
                        rd_cnt     <= 6'h0;
                        inc_cnt    <= 6'h0;
                        dec_cnt    <= 6'h0;
                        sum        <= 22'h0;
                        state      <= cfg.freeze ? ST_PRE : ST_COLLECT;
                    end
                end
                ST_PRE: begin
                    if (timer == 17'h0) begin
                        state <= ST_COLLECT;
                    end else if (tick) begin
                        timer <= timer - 17'h1;
                    end
                end
                ST_COLLECT: begin
                    if (tick && gas_on) begin
                        rd_cnt  <= rd_cnt + 6'h1;
                        sum     <= sum + 22'(sample_data);
                        prev_rd <= sample_data;
                        if (rd_cnt != 6'h0 && sample_data > prev_rd) begin
                            inc_cnt <= inc_cnt + 6'h1;
                        end else if (rd_cnt != 6'h0 && sample_data < prev_rd) begin
                            dec_cnt <= dec_cnt + 6'h1;
                        end
                    end
                    if (last_rd) begin
                        rd_cnt  <= 6'h0;
                        inc_cnt <= 6'h0;
                        dec_cnt <= 6'h0;
                        sum     <= 22'h0;
                        timer   <= cfg.freeze ? {purge, 1'b0} : 17'h0;
                        if (drift && attempts == ATTEMPT_MAX) begin
                            zero_cal         <= prev_zero;
                            span_cal         <= prev_span;
                            cond[AL_LOW_FLOW] <= 1'b1;
                            ev[EV_DRIFT_FAIL] <= 1'b1;
                            state            <= ST_IDLE;
                        end else if (drift) begin
                            attempts <= attempts + 3'h1;
                            state    <= cfg.freeze ? ST_PRE : ST_COLLECT;
                        end else begin
                            if (phase_span) begin
                                span_cal <= sum + 22'(sample_data);
                            end else begin
                                zero_cal <= sum + 22'(sample_data);
                            end
                            state <= ST_POST;
                        end
                    end
                end
                ST_POST: begin
                    if (timer != 17'h0) begin
                        if (tick) begin
                            timer <= timer - 17'h1;
                        end
                    end else if (!phase_span && cfg.full) begin
                        phase_span <= 1'b1;
                        attempts   <= 3'h0;
                        timer      <= {purge, 1'b0};
                        state      <= cfg.freeze ? ST_PRE : ST_COLLECT;
                    end else begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    state <= ST_IDLE;
                    if (delta_ok(zero_cal, span_cal)) begin
                        cond         <= 2'h0;
                        ev[EV_DONE]  <= 1'b1;
                    end else begin
                        zero_cal        <= prev_zero;
                        span_cal        <= prev_span;
                        cond[AL_CAL]    <= 1'b1;
                        ev[EV_CAL_FAIL] <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Valves and output value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zero_valve <= 1'b0;
            span_valve <= 1'b0;
            out_value  <= 16'h0;
        end else begin
            zero_valve <= (state == ST_PRE || state == ST_COLLECT) && !phase_span;
            span_valve <= (state == ST_PRE || state == ST_COLLECT) && phase_span;
            if (!(busy && cfg.freeze)) begin
                out_value <= sample_data;
            end
        end
    end

    // Latched alarms
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm <= 2'h0;
            ackd  <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ev[i + 1]) begin
                    alarm[i] <= 1'b1;
                    ackd[i]  <= 1'b0;
                end else if (alarm[i] && ackd[i] && !cond[i]) begin
                    alarm[i] <= 1'b0;
                    ackd[i]  <= 1'b0;
                end else if (alarm[i] && ack) begin
                    ackd[i] <= 1'b1;
                end
            end
        end
    end

    // Interrupt status, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat               <= 3'h0;
            irq                    <= 1'b0;
            cal_alarm              <= 1'b0;
            low_flow_failure_alarm <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~((do_wr && waddr == IRQ_CLR_OFS) ? wdata[2:0] : 3'h0)) | ev;
            irq      <= |(irq_stat & irq_en);
            cal_alarm              <= alarm[AL_CAL];
            low_flow_failure_alarm <= alarm[AL_LOW_FLOW];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_valves_exclusive: assert property (!(zero_valve && span_valve))
        else $error("both valves driven");
    a_interval_off: assert property (interval == 16'h0 |=> !sched_pend)
        else $error("schedule pending with interval zero");
    a_freeze_hold: assert property (busy && cfg.freeze |=> $stable(out_value))
        else $error("output moved while frozen");
    a_purge_first: assert property (start && cfg.freeze |=> state == ST_PRE ##1 !span_valve)
        else $error("no purge before phase");
    a_span_closed: assert property (state == ST_POST |=> !span_valve && !zero_valve)
        else $error("valve open after phase");
    a_fail_restore: assert property (state == ST_CHECK && !delta_ok(zero_cal, span_cal)
        |=> zero_cal == $past(prev_zero) ##1 alarm[AL_CAL])
        else $error("failed check not restored");
    a_reading_count: assert property (rd_cnt <= READINGS - 6'h01)
        else $error("reading count overrun");
    a_attempts_max: assert property (attempts <= ATTEMPT_MAX)
        else $error("too many drift attempts");
    a_drift_alarm: assert property (last_rd && drift && attempts == ATTEMPT_MAX
        |=> ##1 alarm[AL_LOW_FLOW])
        else $error("drift failure not alarmed");
    a_alarm_latch: assert property (alarm[AL_CAL] && !ackd[AL_CAL] |=> alarm[AL_CAL])
        else $error("alarm cleared without ack");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");

    c_cal_done: cover property (ev[EV_DONE]);
    c_drift_retry: cover property (last_rd && drift && attempts != ATTEMPT_MAX);
    c_cal_fail: cover property (ev[EV_CAL_FAIL]);
    c_full_span: cover property (span_valve);
endmodule : autocal_sequencer

// ==== dv/autocal_partner.sv ====
// Purpose: gas valve and front-panel model for the sequencer bench
// Assumes: a valve is open while its drive is high
// Notes:   mode 0 good gas, 1 weak span, 2 rising zero reading
`timescale 1ns/1ps
module autocal_partner (
    // Clock and bench controls
    input  wire logic        aclk,
    input  wire logic [1:0]  mode,
    input  wire logic        press,
    input  wire logic [15:0] live,
    // Valves and panel
    input  wire logic        zero_valve,
    input  wire logic        span_valve,
    output logic [15:0]      sample_data,
    output logic             up_button
);
    logic [15:0] ramp = 16'h0000;
    always @(posedge aclk) ramp <= ramp + 16'h0001;
    // Gas seen by the cell follows the open valve
    always_comb begin
        if (span_valve) sample_data = (mode == 2'h1) ? 16'h2800 : 16'h5000;
        else if (zero_valve) sample_data = (mode == 2'h1) ? 16'h2000 :
                                           (mode == 2'h2) ? ramp : 16'h1000;
        else sample_data = live;
    end
    assign up_button = press;
endmodule : autocal_partner

// ==== dv/autocal_sequencer_bench.sv ====
// Purpose: self-checking bench for the calibration sequencer
// Assumes: TICK_CYCLES shortened to 4
// Notes:   registers reached over AXI4-Lite
`timescale 1ns/1ps
module autocal_sequencer_bench import autocal_pkg::*;;
    localparam int T = 4;
    logic        aclk = 1'b0, aresetn = 1'b0, press = 1'b0, up_button, irq;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cal_alarm, low_flow_failure_alarm;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        zero_valve, span_valve;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, mode = 2'h0;
    logic [15:0] sample_data, out_value, held, live = 16'h0000;
    int          num_errors = 0, n_tests = 0, zc = 0, zs = 0;

    always #20 aclk = ~aclk;
    always @(posedge aclk) live <= 16'($urandom);
    always @(posedge aclk) if (zero_valve) zc <= zc + 1;

    autocal_sequencer #(.TICK_CYCLES(T)) autocal_sequencer_i (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sample_data, .up_button, .out_value, .cal_alarm,
        .low_flow_failure_alarm, .zero_valve, .span_valve, .irq);
    autocal_partner autocal_partner_i (.aclk, .mode, .press, .live, .zero_valve,
        .span_valve, .sample_data, .up_button);

    function automatic logic [31:0] cal_sum(input logic [15:0] lvl);
        return 32'(READINGS) * 32'(lvl);
    endfunction : cal_sum

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tmo(input bit hit);
        if (hit) begin
            chk("bounded wait", 32'h0, 32'h1);
            complete_run();
        end
    endtask : tmo

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        tmo(n == 50);
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        tmo(n == 50);
    endtask : rd_reg

    task automatic poll(input int b);
        int n;
        for (n = 0; n < 800; n++) begin
            rd_reg(IRQ_STAT_OFS);
            if (rd[b] === 1'b1) break;
        end
        tmo(n == 800);
    endtask : poll

    task automatic wait_sig(input bit sp, input int lim);
        int n;
        for (n = 0; n < lim && (sp ? span_valve : zero_valve) !== 1'b1; n++) @(posedge aclk);
        tmo((sp ? span_valve : zero_valve) !== 1'b1);
    endtask : wait_sig

    task automatic run(input logic [1:0] m, input logic [31:0] cfg);
        mode <= m;
        zs = zc;
        wr(CFG_OFS, cfg);
        wr(IRQ_CLR_OFS, 32'h7);
        wr(CMD_OFS, 32'h1);
        wait_sig(1'b0, 50);
    endtask : run

    task automatic ack;
        press <= 1'b1;
        repeat (3) @(posedge aclk);
        press <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : ack

    initial begin
        void'($urandom(4));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(PURGE_OFS);
        chk("purge reset", 32'h1E, rd);
        rd_reg(INTERVAL_OFS);
        chk("interval reset", 32'h0, rd);
        rd_reg(8'h40);
        chk("unmapped read", 32'h2, 32'(rsp));
        wr(8'h44, 32'h1);
        chk("unmapped write", 32'h2, 32'(rsp));
        held = 16'($urandom);
        wr(INTERVAL_OFS, 32'(held));
        rd_reg(INTERVAL_OFS);
        chk("interval", 32'(held), rd);
        wr(INTERVAL_OFS, 32'h0);
        repeat (300) @(posedge aclk);
        chk("no auto start", 32'h0, 32'(zc));
        $display("test registers done");
        wr(PURGE_OFS, 32'h1);
        wr(IRQ_EN_OFS, 32'h7);
        run(2'h0, 32'h3);
        repeat (2) @(posedge aclk);
        held = out_value;
        repeat (60) @(posedge aclk);
        chk("frozen output", 32'(held), 32'(out_value));
        wait_sig(1'b1, 400);
        chk("zero valve closed", 32'h0, 32'(zero_valve));
        poll(EV_DONE);
        chk("span valve closed", 32'h0, 32'(span_valve));
        chk("purged window", 32'h1, 32'(zc - zs >= 40 * T && zc - zs <= 44 * T));
        rd_reg(ZERO_CAL_OFS);
        chk("zero sum", cal_sum(16'h1000), rd);
        rd_reg(SPAN_CAL_OFS);
        chk("span sum", cal_sum(16'h5000), rd);
        chk("no alarm", 32'h0, 32'(cal_alarm));
        chk("irq raised", 32'h1, 32'(irq));
        wr(IRQ_EN_OFS, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq masked", 32'h0, 32'(irq));
        wr(IRQ_EN_OFS, 32'h7);
        wr(IRQ_CLR_OFS, 32'h7);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test good calibration done");
        run(2'h1, 32'h1);
        repeat (4) @(posedge aclk);
        chk("tracking output", 32'h2000, 32'(out_value));
        poll(EV_CAL_FAIL);
        chk("cal alarm", 32'h1, 32'(cal_alarm));
        rd_reg(ZERO_CAL_OFS);
        chk("restored zero", cal_sum(16'h1000), rd);
        run(2'h0, 32'h1);
        poll(EV_DONE);
        chk("alarm needs ack", 32'h1, 32'(cal_alarm));
        ack();
        chk("alarm acked", 32'h0, 32'(cal_alarm));
        $display("test failed check done");
        run(2'h2, 32'h0);
        poll(EV_DRIFT_FAIL);
        chk("low flow alarm", 32'h1, 32'(low_flow_failure_alarm));
        chk("retry count", 32'h1, 32'(zc - zs > 5 * 40 * T && zc - zs < 7 * 42 * T));
        rd_reg(ZERO_CAL_OFS);
        chk("drift restore", cal_sum(16'h1000), rd);
        ack();
        chk("ack alone", 32'h1, 32'(low_flow_failure_alarm));
        $display("test drift done");
        wr(INTERVAL_OFS, 32'h1);
        wait_sig(1'b0, 30000);
        chk("scheduled start", 32'h1, 32'(zero_valve));
        $display("test schedule done");
        complete_run();
    end
endmodule : autocal_sequencer_bench
